/* rtl/cpss_param_set_switch.sv */
// Controller gain set switch: two gain sets, selection and switching
// time parameters, gradual blending and the unit locate indicator.
// Assumes gains, selection and locate inputs come from logic on
// sys_clk, so none of them is synchronised here.
//
// Contract
// - Two identical gain sets; exactly one drives the controller.
// - Selection is a writable 16-bit parameter, changeable while running.
// - Active set status is read-only, 1 for first, 2 for second.
// - Active status follows the new set only after switching time elapses.
// - Four gains blend gradually over the switching time, 0 to 2000 ms.
// - Set, global gain, blended gain change or integral off start blending.
// - Switching time is 16-bit, takes effect for the next switching event.
// - Locate flag is boolean, 0 inactive, 1 active, inactive by default.
// - Active locate flag flashes the fieldbus status indicator.
`timescale 1ns/1ns
module cpss_param_set_switch import cpss_pkg::*; #(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic paramWrite,
  input wire logic paramRead,
  input wire logic [15:0] paramAddr,
  input wire logic [15:0] paramWrData,
  output logic [15:0] paramRdData,
  output logic paramRdValid,
  input wire logic [63:0] firstGainSetParams,
  input wire logic [63:0] secondGainSetParams,
  input wire logic [15:0] globalGain,
  input wire logic integralOff,
  output logic [63:0] activeGains,
  input wire logic locateUnitFlag,
  input wire logic busStatusLed,
  output logic fieldbusStatusIndicator
);
  // ==========================================================
  // Assertion clocking
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Parameter registers
  logic [15:0] switchTimeReg;
  logic [15:0] setSelectReg;
  logic [15:0] activeSetReg;
  logic [15:0] rdDataReg;
  logic rdValidReg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switchTimeReg <= RST_SWITCH_TIME;
    end else if (paramWrite && paramAddr == OFS_SWITCH_TIME) begin
      switchTimeReg <= paramWrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      setSelectReg <= RST_SET_SELECT;
    end else if (paramWrite && paramAddr == OFS_SET_SELECT) begin
      setSelectReg <= paramWrData;
    end
  end

  // Active set status is read-only; writes to it are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdDataReg <= 16'h0000;
      rdValidReg <= 1'b0;
    end else begin
      rdValidReg <= paramRead;
      if (paramRead) begin
        if (paramAddr == OFS_SWITCH_TIME) begin
          rdDataReg <= switchTimeReg;
        end else if (paramAddr == OFS_ACTIVE_SET) begin
          rdDataReg <= activeSetReg;
        end else if (paramAddr == OFS_SET_SELECT) begin
          rdDataReg <= setSelectReg;
        end else begin
          rdDataReg <= 16'h0000;
        end
      end
    end
  end

  assign paramRdData = rdDataReg;
  assign paramRdValid = rdValidReg;

  // ==========================================================
  // Targets and switching causes
  logic selSecond;
  logic [63:0] targetGains;
  logic [63:0] prevTargets;
  logic [15:0] prevGlobal;
  logic prevIntOff;
  logic initReg;
  logic cause;
  logic [15:0] effTime;
  logic [15:0] pendingSet;

  // Any code other than the second set falls back to the first
  assign selSecond = (setSelectReg == SET_SECOND);
  assign targetGains = selSecond ? secondGainSetParams
                                 : firstGainSetParams;
  assign pendingSet = selSecond ? SET_SECOND : SET_FIRST;
  // Out-of-range times are clamped rather than refused
  assign effTime = (switchTimeReg > MAX_SWITCH_TIME) ? MAX_SWITCH_TIME
                                                     : switchTimeReg;
  assign cause = !initReg && ((targetGains != prevTargets) ||
                 (globalGain != prevGlobal) ||
                 (integralOff && !prevIntOff));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevTargets <= 64'h0000000000000000;
      prevGlobal <= 16'h0000;
      prevIntOff <= 1'b0;
      initReg <= 1'b1;
    end else begin
      prevTargets <= targetGains;
      prevGlobal <= globalGain;
      prevIntOff <= integralOff;
      initReg <= 1'b0;
    end
  end

  // ==========================================================
  // Millisecond tick
  logic [31:0] tickCnt;
  logic msTick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt <= 32'h00000000;
    end else if (tickCnt == 32'(TICK_COUNT - 1)) begin
      tickCnt <= 32'h00000000;
    end else begin
      tickCnt <= tickCnt + 32'h00000001;
    end
  end

  assign msTick = (tickCnt == 32'(TICK_COUNT - 1));

  // ==========================================================
  // Switch sequencer
  cpss_state_t stateReg;
  logic [15:0] elapsedReg;
  logic [15:0] durReg;
  logic [15:0] elapsedNext;
  logic restart;
  logic step;
  logic load;
  logic finish;

  assign elapsedNext = elapsedReg + 16'h0001;
  assign finish = (stateReg == CPSS_BLEND) && !cause && msTick &&
                  (elapsedNext >= durReg);
  assign restart = cause && (effTime != 16'h0000);
  assign step = (stateReg == CPSS_BLEND) && !cause && msTick;
  // Init loads the selected set directly so reset does not blend from 0
  assign load = initReg || (cause && effTime == 16'h0000) || finish;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateReg <= CPSS_IDLE;
      elapsedReg <= 16'h0000;
      durReg <= 16'h0000;
    end else begin
      case (stateReg)
        CPSS_IDLE: begin
          if (restart) begin
            stateReg <= CPSS_BLEND;
            elapsedReg <= 16'h0000;
            durReg <= effTime;
          end
        end
        CPSS_BLEND: begin
          if (cause) begin
            elapsedReg <= 16'h0000;
            durReg <= effTime;
            if (effTime == 16'h0000) begin
              stateReg <= CPSS_IDLE;
            end
          end else if (finish) begin
            stateReg <= CPSS_IDLE;
          end else if (msTick) begin
            elapsedReg <= elapsedNext;
          end
        end
        default: stateReg <= CPSS_IDLE;
      endcase
    end
  end

  // Status moves at init, when the blend completes, or at once on a cause with zero switching time
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      activeSetReg <= SET_FIRST;
    end else if (initReg || finish || (cause && effTime == 16'h0000)) begin
      activeSetReg <= pendingSet;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GAINS; g++) begin : gBlend
      cpss_blend uBlend (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(restart),
        .step(step),
        .load(load),
        .target(targetGains[16*g +: 16]),
        .elapsed(elapsedNext),
        .duration(durReg),
        .value(activeGains[16*g +: 16])
      );
    end
  endgenerate

  // ==========================================================
  // Locate indicator
  logic [15:0] flashCnt;
  logic flashReg;
  logic indReg;

  always_ff @(posedge sys_clk) begin
    if (rst || !locateUnitFlag) begin
      flashCnt <= 16'h0000;
      flashReg <= 1'b0;
    end else if (msTick) begin
      if (flashCnt == FLASH_HALF_TICKS - 16'h0001) begin
        flashCnt <= 16'h0000;
        flashReg <= !flashReg;
      end else begin
        flashCnt <= flashCnt + 16'h0001;
      end
    end
  end

  // Relies on the master only raising locate with the bus running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      indReg <= 1'b0;
    end else begin
      indReg <= locateUnitFlag ? flashReg : busStatusLed;
    end
  end

  assign fieldbusStatusIndicator = indReg;

  // ==========================================================
  // Checks
  sequence blendStart_s;
    restart ##1 (stateReg == CPSS_BLEND && elapsedReg == 16'h0000);
  endsequence

  zero_time_a: assert property (
    cause && effTime == 16'h0000 |=> activeGains == $past(targetGains))
    else $error("zero switching time did not apply gains");
  restart_blend_a: assert property (
    restart |-> blendStart_s)
    else $error("cause did not restart blending");
  status_hold_a: assert property (
    stateReg == CPSS_BLEND && !cause && !finish |=> $stable(activeSetReg))
    else $error("active set changed mid blend");
  status_done_a: assert property (
    finish |=> activeSetReg == $past(pendingSet) && stateReg == CPSS_IDLE)
    else $error("active set not updated at blend end");
  status_code_a: assert property (
    activeSetReg == SET_FIRST || activeSetReg == SET_SECOND)
    else $error("active set code out of range");
  select_read_a: assert property (
    paramRead && paramAddr == OFS_SET_SELECT && !paramWrite
    |=> paramRdValid && paramRdData == $past(setSelectReg))
    else $error("selection read back wrong");
  time_write_a: assert property (
    paramWrite && paramAddr == OFS_SWITCH_TIME
    |=> switchTimeReg == $past(paramWrData))
    else $error("switching time write lost");
  blend_range_a: assert property (
    stateReg == CPSS_BLEND |-> durReg <= MAX_SWITCH_TIME &&
    durReg != 16'h0000)
    else $error("blend duration out of range");
  locate_off_a: assert property (
    !locateUnitFlag |=> fieldbusStatusIndicator == $past(busStatusLed))
    else $error("indicator not following bus status");
  cause_detect_a: assert property (
    !initReg && $rose(integralOff) |-> cause)
    else $error("integral off did not start switching");
endmodule : cpss_param_set_switch

/* rtl/cpss_pkg.sv */
// Constants for the controller gain set switch: parameter offsets,
// reset values and timing.
// Assumes a 125 MHz system clock and a parameter access port driven
// by fieldbus logic on that same clock.
package cpss_pkg;
  // ==========================================================
  // Parameter offsets
  localparam logic [15:0] OFS_SWITCH_TIME = 16'h1128;
  localparam logic [15:0] OFS_ACTIVE_SET = 16'h112E;
  localparam logic [15:0] OFS_SET_SELECT = 16'h1132;
  // ==========================================================
  // Codes and reset values
  localparam logic [15:0] SET_FIRST = 16'h0001;
  localparam logic [15:0] SET_SECOND = 16'h0002;
  localparam logic [15:0] RST_SWITCH_TIME = 16'h0000;
  localparam logic [15:0] RST_SET_SELECT = 16'h0001;
  localparam logic [15:0] MAX_SWITCH_TIME = 16'h07D0;
  localparam int NUM_GAINS = 4;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FLASH_HALF_MS = 250;
  localparam logic [15:0] FLASH_HALF_TICKS = 16'(FLASH_HALF_MS);
  // ==========================================================
  // Switch sequencer states
  typedef enum logic [1:0] {
    CPSS_IDLE = 2'b01,
    CPSS_BLEND = 2'b10
  } cpss_state_t;
endpackage : cpss_pkg

/* rtl/cpss_blend.sv */
// One blended gain channel: linear interpolation from a captured start
// value toward a target.
// Assumes the sequencer supplies restart, step and load pulses and a
// nonzero duration whenever step is high.
`timescale 1ns/1ns
module cpss_blend import cpss_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic step,
  input wire logic load,
  input wire logic [15:0] target,
  input wire logic [15:0] elapsed,
  input wire logic [15:0] duration,
  output logic [15:0] value
);
  // ==========================================================
  // Interpolation
  logic [15:0] startReg;
  logic [15:0] valueReg;
  logic signed [16:0] diff;
  logic signed [28:0] prod;
  logic signed [28:0] quot;
  logic signed [16:0] sum;
  logic [11:0] divisor;

  // Divisor kept nonzero so an idle zero duration never divides by zero
  assign divisor = (duration == 16'h0000) ? 12'h001 : {1'b0, duration[10:0]};
  assign diff = $signed({1'b0, target}) - $signed({1'b0, startReg});
  assign prod = diff * $signed({1'b0, elapsed[10:0]});
  assign quot = prod / $signed({1'b0, divisor});
  assign sum = $signed({1'b0, startReg}) + quot[16:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      startReg <= 16'h0000;
    end else if (restart) begin
      startReg <= valueReg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valueReg <= 16'h0000;
    end else if (load) begin
      valueReg <= target;
    end else if (step) begin
      valueReg <= sum[15:0];
    end
  end

  assign value = valueReg;
endmodule : cpss_blend

/* verification/cpss_master_model.sv */
// Fieldbus master model: parameter writes and reads, locate flag.
// Assumes the block answers a read one cycle after the strobe edge.
`timescale 1ns/1ns
module cpss_master_model (
  input wire logic sys_clk,
  output logic paramWrite,
  output logic paramRead,
  output logic [15:0] paramAddr,
  output logic [15:0] paramWrData,
  input wire logic [15:0] paramRdData,
  input wire logic paramRdValid,
  output logic locateUnitFlag
);
  // ==========================================================
  // Link state
  logic commUp;
  initial begin
    paramWrite = 1'b0;
    paramRead = 1'b0;
    paramAddr = 16'h0000;
    paramWrData = 16'hA5A5;
    locateUnitFlag = 1'b0;
    commUp = 1'b0;
  end
  // ==========================================================
  // Access tasks
  // Whole 16-bit words only; data is scrambled once released
  task automatic writeParam(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    paramWrite <= 1'b1;
    paramAddr <= a;
    paramWrData <= d;
    @(posedge sys_clk);
    paramWrite <= 1'b0;
    paramWrData <= ~d;
    commUp = 1'b1;
  endtask : writeParam
  task automatic readParam(input logic [15:0] a, output logic [15:0] d,
                           output logic ok);
    @(posedge sys_clk);
    paramRead <= 1'b1;
    paramAddr <= a;
    @(posedge sys_clk);
    paramRead <= 1'b0;
    #1;
    ok = paramRdValid;
    d = paramRdData;
  endtask : readParam
  // Boolean flag, raised only once the link is running
  task automatic setLocate(input logic on);
    @(posedge sys_clk);
    locateUnitFlag <= on & commUp;
  endtask : setLocate
endmodule : cpss_master_model

/* verification/cpss_param_set_switch_tb.sv */
// Testbench for the gain set switch, with a short millisecond tick.
// Assumes the master model drives the parameter port and locate flag.
`timescale 1ns/1ns
module cpss_param_set_switch_tb import cpss_pkg::*;;
  // ==========================================================
  // Stimulus and wiring
  localparam logic [63:0] S1 = 64'h0400_0300_0200_0100;
  localparam logic [63:0] S2 = 64'h0800_0700_0600_0500;
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic pW, pR, pV, locate, ind, intOff = 1'b0;
  logic busLed = 1'b0;
  logic [15:0] pA, pD, pQ;
  logic [15:0] gGain = 16'h0100;
  logic [63:0] first = S1;
  logic [63:0] gains;
  int failures = 0;
  int checksDone = 0;
  initial begin
    forever #4 sysClk = ~sysClk;
  end
  cpss_master_model i_master (.sys_clk(sysClk), .paramWrite(pW),
    .paramRead(pR), .paramAddr(pA), .paramWrData(pD), .paramRdData(pQ),
    .paramRdValid(pV), .locateUnitFlag(locate));
  cpss_param_set_switch #(.TICK_COUNT(10)) i_dut (.sys_clk(sysClk),
    .rst(rst), .paramWrite(pW), .paramRead(pR), .paramAddr(pA),
    .paramWrData(pD), .paramRdData(pQ), .paramRdValid(pV),
    .firstGainSetParams(first), .secondGainSetParams(S2),
    .globalGain(gGain), .integralOff(intOff), .activeGains(gains),
    .locateUnitFlag(locate), .busStatusLed(busLed),
    .fieldbusStatusIndicator(ind));
  // ==========================================================
  // Shared helpers
  task automatic check(input bit ok, input string msg);
    checksDone++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic expectRead(input logic [15:0] a, input logic [15:0] want);
    logic [15:0] d;
    logic ok;
    i_master.readParam(a, d, ok);
    check(ok === 1'b1 && d === want, "read value wrong");
  endtask : expectRead
  // Bounded wait for the gains to settle; also notes an in-between value
  task automatic waitGains(input logic [63:0] want, output int n,
                           output bit mid);
    mid = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge sysClk);
      #1;
      if (gains === want) begin
        return;
      end
      if (gains[15:0] !== S1[15:0] && gains[15:0] !== S2[15:0]) begin
        mid = 1;
      end
    end
    check(1'b0, "gains never settled");
    tally_and_finish();
  endtask : waitGains
  // Bounded wait for the indicator to change; gives the cycles taken
  task automatic waitToggle(output int n);
    logic last;
    last = ind;
    for (n = 1; n <= 2600; n++) begin
      @(posedge sysClk);
      #1;
      if (ind !== last) begin
        return;
      end
    end
    check(1'b0, "indicator never changed");
    tally_and_finish();
  endtask : waitToggle
  // ==========================================================
  // Scenarios
  task automatic testRegisters;
    expectRead(OFS_ACTIVE_SET, SET_FIRST);
    expectRead(OFS_SET_SELECT, RST_SET_SELECT);
    expectRead(OFS_SWITCH_TIME, RST_SWITCH_TIME);
    check(gains === S1, "first set not driving");
    i_master.writeParam(OFS_ACTIVE_SET, SET_SECOND);
    expectRead(OFS_ACTIVE_SET, SET_FIRST);
    expectRead(16'h1130, 16'h0000);
    i_master.writeParam(OFS_SWITCH_TIME, 16'hFFFF);
    expectRead(OFS_SWITCH_TIME, 16'hFFFF);
    i_master.writeParam(OFS_SWITCH_TIME, 16'h0000);
    i_master.writeParam(OFS_SET_SELECT, 16'h0003);
    expectRead(OFS_SET_SELECT, 16'h0003);
    expectRead(OFS_ACTIVE_SET, SET_FIRST);
    check(gains === S1, "odd code left first set");
    $display("test registers done");
  endtask : testRegisters
  task automatic testZeroTime;
    i_master.writeParam(OFS_SET_SELECT, SET_SECOND);
    repeat (3) @(posedge sysClk);
    #1;
    check(gains === S2, "zero time not applied at once");
    expectRead(OFS_ACTIVE_SET, SET_SECOND);
    $display("test zero time done");
  endtask : testZeroTime
  task automatic testTimedBlend;
    int n;
    bit mid;
    i_master.writeParam(OFS_SWITCH_TIME, 16'h0004);
    i_master.writeParam(OFS_SET_SELECT, SET_FIRST);
    expectRead(OFS_ACTIVE_SET, SET_SECOND);
    waitGains(S1, n, mid);
    check(n >= 25 && n <= 45, "blend length wrong");
    check(mid, "no intermediate gain seen");
    expectRead(OFS_ACTIVE_SET, SET_FIRST);
    $display("test timed blend done");
  endtask : testTimedBlend
  // Global gain, then integral off, each restarts a running blend
  task automatic testRestart;
    int n;
    bit mid;
    for (int c = 0; c < 2; c++) begin
      i_master.writeParam(OFS_SET_SELECT, c == 0 ? SET_SECOND : SET_FIRST);
      repeat (20) @(posedge sysClk);
      if (c == 0) begin
        gGain <= gGain + 16'h0001;
      end else begin
        intOff <= 1'b1;
      end
      waitGains(c == 0 ? S2 : S1, n, mid);
      check(n >= 28, "blend not restarted");
    end
    @(posedge sysClk);
    intOff <= 1'b0;
    $display("test restart done");
  endtask : testRestart
  task automatic testGainEdit;
    i_master.writeParam(OFS_SWITCH_TIME, 16'h0000);
    first <= S1 ^ 64'h0011_0000_0022_0000;
    repeat (3) @(posedge sysClk);
    #1;
    check(gains === (S1 ^ 64'h0011_0000_0022_0000), "edit ignored");
    $display("test gain edit done");
  endtask : testGainEdit
  // First flash half depends on tick phase, so the second one is timed
  task automatic testLocate;
    int n;
    @(posedge sysClk);
    busLed <= 1'b1;
    repeat (3) @(posedge sysClk);
    #1;
    check(ind === 1'b1, "indicator not passed through");
    i_master.setLocate(1'b1);
    waitToggle(n);
    waitToggle(n);
    waitToggle(n);
    check(n >= 2499 && n <= 2501, "flash period wrong");
    i_master.setLocate(1'b0);
    repeat (3) @(posedge sysClk);
    #1;
    check(ind === 1'b1, "indicator not restored");
    $display("test locate done");
  endtask : testLocate
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sysClk);
    rst <= 1'b0;
    testRegisters();
    testZeroTime();
    testTimedBlend();
    testRestart();
    testGainEdit();
    testLocate();
    tally_and_finish();
  end
endmodule : cpss_param_set_switch_tb
